// ### include/sfr_space_pkg.sv
/*
 * constants, types and decode helpers for the special function register
 * window decoder.
 * assumes a classic wishbone master with 32-bit data and byte addresses.
 */
//
// Contract
// - decode indices 0000h to 07FFh as the special function register window.
// - a read of an unimplemented address inside the window returns zero.
// - registers live in aligned 32-byte regions; other regions hold nothing.
// - each module's registers sit together inside that module's own region; two core working registers are decoded at 8000h and 9000h instead.
// - regions follow the coarse map: core, timers, serial, converter, misc.
// - 16-bit words: low byte at the even address, high byte at the odd one; the code holds both at the even index, on lanes 0 and 1.
`default_nettype none

package sfr_space_pkg;

	// ==========================================================
	// address layout
	localparam int          ADR_W        = 18;
	localparam int          IDX_W        = 16;
	localparam int          NUM_WORK     = 13;
	localparam logic [15:0] WIN_FIRST    = 16'h0000;
	localparam logic [15:0] WIN_LAST     = 16'h07FF;
	localparam int          REGION_LSB   = 5;
	localparam int          REGION_MSB   = 10;
	localparam logic [15:0] WORK_RESET   = 16'h0000;

	// printed offsets of the core working registers, entry n is work_reg_n
	localparam logic [NUM_WORK-1:0][15:0] WORK_OFFSET = {
		16'h0018, 16'h0016, 16'h0014, 16'h0012, 16'h0010,
		16'h000E, 16'h000C, 16'h000A, 16'h8000, 16'h9000,
		16'h0004, 16'h0002, 16'h0000
	};

	// ==========================================================
	// module owning a region
	typedef enum logic [3:0] {
		MOD_NONE    = 4'h0,
		MOD_CORE    = 4'h1,
		MOD_PCN     = 4'h2,
		MOD_INTR    = 4'h3,
		MOD_TIMER   = 4'h4,
		MOD_CAPTURE = 4'h5,
		MOD_COMPARE = 4'h6,
		MOD_SERIAL  = 4'h7,
		MOD_IO      = 4'h8,
		MOD_CONVERT = 4'h9,
		MOD_PPORT   = 4'hA,
		MOD_CLOCK   = 4'hB,
		MOD_CRC     = 4'hC,
		MOD_PINSEL  = 4'hD,
		MOD_SYSTEM  = 4'hE,
		MOD_NVM     = 4'hF
	} module_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_DECODE = 2'b01,
		ST_ACK    = 2'b10
	} bus_state_t;

	typedef enum logic [1:0] {
		SRC_ZERO  = 2'b00,
		SRC_CORE  = 2'b01,
		SRC_PERIPH = 2'b10
	} read_src_t;

	// one access handed to the module that owns the region
	typedef struct packed {
		logic        valid;
		logic        we;
		module_t     owner;
		logic [10:0] offset;
		logic [1:0]  byte_en;
		logic [15:0] wdata;
	} periph_access_t;

	// ==========================================================
	// region map, region number is index bits 10..5
	function automatic module_t region_owner(input logic [5:0] region);
		module_t m;
		m = MOD_NONE;
		case (region)
			6'h00, 6'h01, 6'h02: m = MOD_CORE;
			6'h03, 6'h04:        m = MOD_PCN;
			6'h05, 6'h06:        m = MOD_INTR;
			6'h08, 6'h09:        m = MOD_TIMER;
			6'h0A, 6'h0B, 6'h0C: m = MOD_CAPTURE;
			6'h0D, 6'h0E, 6'h0F: m = MOD_COMPARE;
			6'h10, 6'h11, 6'h12,
			6'h13, 6'h14, 6'h15: m = MOD_SERIAL;
			6'h16, 6'h17:        m = MOD_IO;
			6'h18, 6'h19:        m = MOD_CONVERT;
			6'h30:               m = MOD_PPORT;
			6'h31:               m = MOD_CLOCK;
			6'h32:               m = MOD_CRC;
			6'h34, 6'h35, 6'h36: m = MOD_PINSEL;
			6'h3A:               m = MOD_SYSTEM;
			6'h3B:               m = MOD_NVM;
			default:             m = MOD_NONE;
		endcase
		return m;
	endfunction

endpackage

`default_nettype wire

// ### logic/sfr_space_decode.sv
/*
 * special function register window decoder: core working registers held
 * here, every other implemented region forwarded to its owning module.
 * assumes a classic wishbone master and owners that answer read data
 * combinationally in the cycle their access strobe is high.
 */
`timescale 1ns/1ps
`default_nettype none

module sfr_space_decode
(
	// clock and reset
	input  wire logic                          i_clk,
	input  wire logic                          i_srst,
	// wishbone slave
	input  wire logic                          i_wb_cyc,
	input  wire logic                          i_wb_stb,
	input  wire logic                          i_wb_we,
	input  wire logic [sfr_space_pkg::ADR_W-1:0] i_wb_adr,
	input  wire logic [3:0]                    i_wb_sel,
	input  wire logic [31:0]                   i_wb_dat,
	output var  logic [31:0]                   o_wb_dat,
	output var  logic                          o_wb_ack,
	// region owners
	output var  sfr_space_pkg::periph_access_t o_periph,
	input  wire logic [15:0]                   i_periph_rdata
);

	// ==========================================================
	// state
	typedef struct packed {
		sfr_space_pkg::bus_state_t                st;
		logic                                     ack;
		logic [31:0]                              dat;
		sfr_space_pkg::read_src_t                 src;
		logic [3:0]                               core_sel;
		sfr_space_pkg::periph_access_t            acc;
		logic [sfr_space_pkg::NUM_WORK-1:0][15:0] work;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// ==========================================================
	// request decode
	logic [15:0]             idx;
	logic                    in_window;
	sfr_space_pkg::module_t  owner;
	logic                    core_hit;
	logic [3:0]              core_n;
	logic                    take;

	assign idx       = i_wb_adr[sfr_space_pkg::ADR_W-1:2];
	assign in_window = (idx >= sfr_space_pkg::WIN_FIRST)
		&& (idx <= sfr_space_pkg::WIN_LAST);
	assign owner     = in_window ? sfr_space_pkg::region_owner(
		idx[sfr_space_pkg::REGION_MSB:sfr_space_pkg::REGION_LSB])
		: sfr_space_pkg::MOD_NONE;
	assign take      = i_wb_cyc && i_wb_stb
		&& (s_r.st == sfr_space_pkg::ST_IDLE);

	always_comb
	begin
		core_hit = 1'b0;
		core_n   = 4'h0;
		for (int n = 0; n < sfr_space_pkg::NUM_WORK; n++)
		begin
			if (idx == sfr_space_pkg::WORK_OFFSET[n])
			begin
				core_hit = 1'b1;
				core_n   = 4'(n);
			end
		end
	end

	// ==========================================================
	// next state
	always_comb
	begin
		s_nxt            = s_r;
		s_nxt.acc.valid  = 1'b0;
		case (s_r.st)
			sfr_space_pkg::ST_IDLE:
			begin
				s_nxt.ack = 1'b0;
				if (take)
				begin
					s_nxt.st       = sfr_space_pkg::ST_DECODE;
					s_nxt.core_sel = core_n;
					s_nxt.src      = sfr_space_pkg::SRC_ZERO;
					if (core_hit)
					begin
						s_nxt.src = sfr_space_pkg::SRC_CORE;
						if (i_wb_we)
						begin
							// low byte on lane 0, high byte on lane 1
							if (i_wb_sel[0])
								s_nxt.work[core_n][7:0] = i_wb_dat[7:0];
							if (i_wb_sel[1])
								s_nxt.work[core_n][15:8] = i_wb_dat[15:8];
						end
					end
					else if (owner != sfr_space_pkg::MOD_NONE
						&& owner != sfr_space_pkg::MOD_CORE)
					begin
						// forward only into a region that owns registers
						s_nxt.src         = sfr_space_pkg::SRC_PERIPH;
						s_nxt.acc.valid   = 1'b1;
						s_nxt.acc.we      = i_wb_we;
						s_nxt.acc.owner   = owner;
						s_nxt.acc.offset  = idx[10:0];
						s_nxt.acc.byte_en = i_wb_sel[1:0];
						s_nxt.acc.wdata   = i_wb_dat[15:0];
					end
					// anything else is dropped without effect
				end
			end
			sfr_space_pkg::ST_DECODE:
			begin
				s_nxt.st  = sfr_space_pkg::ST_ACK;
				s_nxt.ack = 1'b1;
				case (s_r.src)
					sfr_space_pkg::SRC_CORE:
						s_nxt.dat = {16'h0000, s_r.work[s_r.core_sel]};
					sfr_space_pkg::SRC_PERIPH:
						s_nxt.dat = s_r.acc.we ? 32'h0000_0000
							: {16'h0000, i_periph_rdata};
					default:
						s_nxt.dat = 32'h0000_0000;
				endcase
			end
			sfr_space_pkg::ST_ACK:
			begin
				s_nxt.st  = sfr_space_pkg::ST_IDLE;
				s_nxt.ack = 1'b0;
			end
			default:
			begin
				s_nxt.st  = sfr_space_pkg::ST_IDLE;
				s_nxt.ack = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			s_r          <= '0;
			s_r.st       <= sfr_space_pkg::ST_IDLE;
			s_r.src      <= sfr_space_pkg::SRC_ZERO;
			s_r.acc.owner <= sfr_space_pkg::MOD_NONE;
			for (int n = 0; n < sfr_space_pkg::NUM_WORK; n++)
				s_r.work[n] <= sfr_space_pkg::WORK_RESET;
		end
		else
			s_r <= s_nxt;
	end

	assign o_wb_ack = s_r.ack;
	assign o_wb_dat = s_r.dat;
	assign o_periph = s_r.acc;

endmodule

`default_nettype wire

// ### tb/sfr_owner_model.sv
/* stand-in for the modules that own the forwarded regions.
   assumes read data is wanted only while the access strobe is high */
`timescale 1ns/1ps
`default_nettype none
module sfr_owner_model
(
	// clock
	input  wire logic                          i_clk,
	// access from the decoder and data back
	input  wire sfr_space_pkg::periph_access_t i_access,
	output var  logic [15:0]                   o_rdata
);
	logic flip_r = 1'b0;
	always_ff @(posedge i_clk)
	begin
		flip_r <= !flip_r;
	end
	// outside a strobe the data wobbles so stale values cannot pass
	assign o_rdata = i_access.valid ?
		{i_access.owner, i_access.offset, 1'b1} : {16{flip_r}};
endmodule
`default_nettype wire

// ### tb/sfr_space_decode_checker.sv
/* timing and decode assertions on the decoder ports.
   assumes a master that holds stb until ack */
`timescale 1ns/1ps
`default_nettype none
module sfr_space_decode_checker
(
	// watched ports
	input wire logic                          i_clk,
	input wire logic                          i_srst,
	input wire logic                          i_wb_cyc,
	input wire logic                          i_wb_stb,
	input wire logic                          i_wb_we,
	input wire logic [sfr_space_pkg::ADR_W-1:0] i_wb_adr,
	input wire logic [3:0]                    i_wb_sel,
	input wire logic [31:0]                   i_wb_dat,
	input wire logic [31:0]                   o_wb_dat,
	input wire logic                          o_wb_ack,
	input wire sfr_space_pkg::periph_access_t o_periph,
	input wire logic [15:0]                   i_periph_rdata
);
	logic [15:0] idx;
	logic [1:0]  sel_lo;
	assign idx = i_wb_adr[17:2];
	assign sel_lo = i_wb_sel[1:0];
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	ack_delay_a: assert property ($rose(i_wb_stb) |-> ##2 o_wb_ack)
		else $error("ack late");
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack long");
	high_zero_a: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0000)
		else $error("high half set");
	outside_zero_a: assert property ($rose(i_wb_stb) && !i_wb_we &&
		idx[15:11] != 5'h00 && idx[15:13] != 3'h4 |-> ##2 o_wb_dat == 32'h0)
		else $error("outside read not zero");
	hole_write_a: assert property ($rose(i_wb_stb) && i_wb_we &&
		idx[15:9] == 7'h02 |=> !o_periph.valid) else $error("hole forwarded");
	owner_data_a: assert property (o_periph.valid && !o_periph.we |=>
		o_wb_dat[15:0] == $past(i_periph_rdata)) else $error("owner data lost");
	fwd_field_a: assert property (o_periph.valid |->
		o_periph.offset == $past(idx[10:0]) && o_periph.byte_en == $past(sel_lo))
		else $error("forwarded fields wrong");
	fwd_data_a: assert property (o_periph.valid |->
		o_periph.we == $past(i_wb_we) && o_periph.wdata == $past(i_wb_dat[15:0]))
		else $error("forwarded data wrong");
	conv_row_a: assert property ($rose(i_wb_stb) && idx[15:6] == 10'h00C |=>
		o_periph.valid && o_periph.owner == sfr_space_pkg::MOD_CONVERT)
		else $error("converter row not forwarded");
endmodule
bind sfr_space_decode sfr_space_decode_checker sfr_space_decode_checker_inst (
	.i_clk(i_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
	.i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.o_periph(o_periph), .i_periph_rdata(i_periph_rdata));
`default_nettype wire

// ### tb/sfr_space_decode_tb.sv
/* bench for the register window decoder: wishbone calls with expected
   values; region owners come from sfr_owner_model */
`timescale 1ns/1ps
`default_nettype none
module sfr_space_decode_tb;
	logic        i_clk = 1'b0;
	logic        i_srst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [17:0] adr = 18'h00000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic        ack;
	logic [15:0] prd;
	logic [15:0] rd;
	sfr_space_pkg::periph_access_t acc_s;
	int          n_errors = 0;
	int          check_count = 0;
	logic [15:0] hole [4] = '{16'h001A, 16'h00E0, 16'h0400, 16'h0800};
	logic [15:0] pidx [6] = '{16'h0060, 16'h0100, 16'h0200, 16'h0300,
		16'h0600, 16'h0760};
	logic [3:0]  pown [6] = '{4'h2, 4'h4, 4'h7, 4'h9, 4'hA, 4'hF};
	always #5 i_clk = !i_clk;
	sfr_space_decode sfr_space_decode_inst (.i_clk(i_clk), .i_srst(i_srst),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.o_periph(acc_s), .i_periph_rdata(prd));
	sfr_owner_model sfr_owner_model_inst (.i_clk(i_clk), .i_access(acc_s),
		.o_rdata(prd));
	// ==========================================================
	// bus and compare tasks
	task automatic check(input string what, input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic xfer(input logic w, input logic [15:0] i,
		input logic [1:0] bs, input logic [15:0] wd);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		sel <= {2'b00, bs};
		wdat <= {16'h0000, wd};
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		// a missing acknowledge counts as a mismatch
		if (ack !== 1'b1)
			n_errors++;
		rd = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================================
	// tests
	initial
	begin
		repeat (20) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		for (int i = 0; i < 13; i++)
		begin
			xfer(1'b0, sfr_space_pkg::WORK_OFFSET[i], 2'h3, 16'h0000);
			check("work reset", rd, 16'h0000);
			xfer(1'b1, sfr_space_pkg::WORK_OFFSET[i], 2'h3, {i[7:0], ~i[7:0]});
		end
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b1, hole[i], 2'h3, 16'hFFFF);
			xfer(1'b0, hole[i], 2'h3, 16'h0000);
			check("hole", rd, 16'h0000);
		end
		xfer(1'b1, 16'h0000, 2'h2, 16'h5A00);
		for (int i = 0; i < 13; i++)
		begin
			xfer(1'b0, sfr_space_pkg::WORK_OFFSET[i], 2'h3, 16'h0000);
			check("work", rd, i == 0 ? 16'h5AFF : {i[7:0], ~i[7:0]});
		end
		for (int i = 0; i < 6; i++)
		begin
			xfer(1'b0, pidx[i], 2'h3, 16'h0000);
			check("owner", rd, {pown[i], pidx[i][10:0], 1'b1});
			xfer(1'b1, pidx[i], 2'h1, 16'h1234);
		end
		close_out();
	end
	initial
	begin
		#100us;
		n_errors++;
		close_out();
	end
endmodule
`default_nettype wire
